// ==== hdl/dcbd_pkg.sv ====
// Package of constants and types for the DC bridge drive control block
package dcbd_pkg;

	// ------------------------------------------------------------
	// Clock rate
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 250;                       // Core clock rate in MHz

	// ------------------------------------------------------------
	// Timing figures in their own units
	// ------------------------------------------------------------
	localparam int OFF_TIME_NOM_US = 25;                // Fixed off-time, nominal
	localparam int OFF_TIME_MIN_US = 16;                // Fixed off-time, least
	localparam int OFF_TIME_MAX_US = 34;                // Fixed off-time, longest
	localparam int DEAD_TIME_MIN_NS = 50;               // Crossover dead time, least
	localparam int STANDBY_DELAY_MS = 1;                // Standby delay
	localparam int RETRY_DELAY_MS = 2;                  // Overcurrent retry timeout
	localparam int OC_QUALIFY_MIN_US = 1;               // Overcurrent pulse width, least
	localparam int WAKE_SETTLE_US = 30;                 // Charge pump settle, longest

	// ------------------------------------------------------------
	// Derived cycle counts
	// ------------------------------------------------------------
	localparam int OFF_TIME_CYC = OFF_TIME_NOM_US * CLK_MHZ;
	localparam int FAST_HALF_CYC = OFF_TIME_CYC / 2;
	localparam int DEAD_TIME_CYC = (DEAD_TIME_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int STANDBY_CYC = STANDBY_DELAY_MS * 1000 * CLK_MHZ;
	localparam int RETRY_CYC = RETRY_DELAY_MS * 1000 * CLK_MHZ;
	localparam int OC_QUALIFY_CYC = OC_QUALIFY_MIN_US * CLK_MHZ;
	localparam int WAKE_SETTLE_CYC = WAKE_SETTLE_US * CLK_MHZ;
	localparam int CNT_W = 20;                          // Width of every timer

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic RST_STANDBY = 1'b1;                // Wake up in standby

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		DCBD_DRIVE = 3'b000,                            // Diagonal pair on
		DCBD_FAST  = 3'b001,                            // Fast decay half
		DCBD_DEAD  = 3'b010,                            // All drivers off
		DCBD_SLOW  = 3'b011                             // Slow decay rest
	} dcbd_chop_t;

	typedef struct packed {
		logic hi;                                        // High-side gate on
		logic lo;                                        // Low-side gate on
	} dcbd_leg_t;

	typedef struct packed {
		logic input_a;                                   // Direction input a
		logic input_b;                                   // Direction input b
	} dcbd_cmd_t;

endpackage

// ==== hdl/dcbd_top.sv ====
// DC bridge drive control: direction decode, chopper, standby and protection
// Functional notes
// - Input patterns select forward, reverse, brake.
// - Forward trip: out_a low, out_b chops.
// - Reverse trip: out_b low, out_a chops.
// - Both inputs low coasts outputs high-Z.
// - Inputs low over 1 ms enter standby.
// - Trip resets latch, turns pair off.
// - Fixed off-time 25 us per trip.
// - Fast decay first half, slow rest.
// - Dead time between fast and slow.
// - Short detected pulls fault output low.
// - Retry grounded re-enables after 2 ms.
// - Retry open latches fault until standby.
// - No-retry variant always latches fault.
// - Thermal shutdown disables bridge outputs.
// - Undervoltage keeps all drivers off.
`timescale 1ns/1ps
module dcbd_top
	import dcbd_pkg::*;
#(
	parameter int OFF_CYC     = dcbd_pkg::OFF_TIME_CYC,
	parameter int STANDBY_P   = dcbd_pkg::STANDBY_CYC,
	parameter int RETRY_P     = dcbd_pkg::RETRY_CYC,
	parameter bit HAS_RETRY   = 1'b1
) (
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                arst_n,
	// Controller inputs
	input  wire dcbd_pkg::dcbd_cmd_t cmd,
	input  wire logic                retry_select,
	// Analog monitor results
	input  wire logic                trip_cmp,
	input  wire logic                overcurrent_guard,
	input  wire logic                thermal_hot,
	input  wire logic                supply_lockout,
	// Bridge gates
	output dcbd_pkg::dcbd_leg_t      bridge_out_a,
	output dcbd_pkg::dcbd_leg_t      bridge_out_b,
	// Status pins
	output logic                     standby,
	output logic                     fault_out_low_o,
	output logic                     fault_out_low_oe
);
	import dcbd_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	dcbd_chop_t       chop_reg;                         // Chopper phase
	logic [CNT_W-1:0] off_cnt_reg;                      // Off-time counter
	logic [CNT_W-1:0] dead_cnt_reg;                     // Dead-time counter
	logic [CNT_W-1:0] sby_cnt_reg;                      // Standby counter
	logic [CNT_W-1:0] oc_cnt_reg;                       // Overcurrent qualify
	logic [CNT_W-1:0] rty_cnt_reg;                      // Retry timeout
	logic             fault_reg;                        // Overcurrent fault held
	logic             thermal_reg;                      // Thermal lockout, follows comparator
	logic             coast;                            // Both inputs low
	logic             fwd;                              // Forward command
	logic             rev;                              // Reverse command
	logic             kill;                             // Force all off
	logic             latch_mode;                       // Fault latches
	logic             oc_qual;                          // Qualified overcurrent
	dcbd_leg_t        a_next;                           // Leg a next gates
	dcbd_leg_t        b_next;                           // Leg b next gates

	assign coast = !cmd.input_a && !cmd.input_b;
	assign fwd = cmd.input_a && !cmd.input_b;
	assign rev = !cmd.input_a && cmd.input_b;
	assign latch_mode = !HAS_RETRY || retry_select;
	assign kill = fault_reg || thermal_reg || supply_lockout || standby;
	assign oc_qual = oc_cnt_reg >= CNT_W'(OC_QUALIFY_CYC - 1) && overcurrent_guard;

	// ------------------------------------------------------------
	// Chopper phase sequencer
	// ------------------------------------------------------------
	// Phases only advance while driving a direction; brake and coast reset it.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			chop_reg <= DCBD_DRIVE;
			off_cnt_reg <= '0;
			dead_cnt_reg <= '0;
		end else if (!(fwd || rev) || kill) begin
			chop_reg <= DCBD_DRIVE;
			off_cnt_reg <= '0;
			dead_cnt_reg <= '0;
		end else begin
			case (chop_reg)
				DCBD_DRIVE: begin
					off_cnt_reg <= '0;
					dead_cnt_reg <= '0;
					if (trip_cmp) begin
						chop_reg <= DCBD_FAST;
					end
				end
				DCBD_FAST: begin
					off_cnt_reg <= off_cnt_reg + 1'b1;
					if (off_cnt_reg >= CNT_W'(OFF_CYC / 2 - 1)) begin
						chop_reg <= DCBD_DEAD;
					end
				end
				DCBD_DEAD: begin
					off_cnt_reg <= off_cnt_reg + 1'b1;
					dead_cnt_reg <= dead_cnt_reg + 1'b1;
					if (dead_cnt_reg >= CNT_W'(DEAD_TIME_CYC - 1)) begin
						chop_reg <= DCBD_SLOW;
					end
				end
				DCBD_SLOW: begin
					off_cnt_reg <= off_cnt_reg + 1'b1;
					if (off_cnt_reg >= CNT_W'(OFF_CYC - 1)) begin
						chop_reg <= DCBD_DRIVE;
					end
				end
				default: begin
					chop_reg <= DCBD_DRIVE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Gate decode
	// ------------------------------------------------------------
	// Chopping leg toggles high in fast decay, low in slow decay.
	always_comb begin
		a_next = '0;
		b_next = '0;
		if (kill || coast) begin
			a_next = '0;
			b_next = '0;
		end else if (cmd.input_a && cmd.input_b) begin
			a_next = 2'b01;
			b_next = 2'b01;
		end else if (chop_reg == DCBD_DRIVE) begin
			a_next = fwd ? 2'b10 : 2'b01;
			b_next = fwd ? 2'b01 : 2'b10;
		end else if (chop_reg == DCBD_DEAD) begin
			a_next = '0;
			b_next = '0;
		end else if (fwd) begin
			a_next = 2'b01;
			b_next = (chop_reg == DCBD_FAST) ? 2'b10 : 2'b01;
		end else begin
			b_next = 2'b01;
			a_next = (chop_reg == DCBD_FAST) ? 2'b10 : 2'b01;
		end
	end

	// Registered gates so outputs come straight from flops
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bridge_out_a <= '0;
			bridge_out_b <= '0;
		end else begin
			bridge_out_a <= a_next;
			bridge_out_b <= b_next;
		end
	end

	// ------------------------------------------------------------
	// Standby timer
	// ------------------------------------------------------------
	// Any non-coast input wakes at once; the host owns the settle wait.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sby_cnt_reg <= '0;
			standby <= RST_STANDBY;
		end else if (!coast) begin
			sby_cnt_reg <= '0;
			standby <= 1'b0;
		end else if (sby_cnt_reg >= CNT_W'(STANDBY_P - 1)) begin
			standby <= 1'b1;
		end else begin
			sby_cnt_reg <= sby_cnt_reg + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Overcurrent qualify, fault and retry
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			oc_cnt_reg <= '0;
		end else if (!overcurrent_guard || fault_reg) begin
			oc_cnt_reg <= '0;
		end else if (!oc_qual) begin
			oc_cnt_reg <= oc_cnt_reg + 1'b1;
		end
	end

	// New qualified overcurrent wins over any clear in the same cycle.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_reg <= 1'b0;
			rty_cnt_reg <= '0;
		end else if (oc_qual) begin
			fault_reg <= 1'b1;
			rty_cnt_reg <= '0;
		end else if (fault_reg && standby) begin
			fault_reg <= 1'b0;
		end else if (fault_reg && !latch_mode) begin
			if (rty_cnt_reg >= CNT_W'(RETRY_P - 1)) begin
				fault_reg <= 1'b0;
				rty_cnt_reg <= '0;
			end else begin
				rty_cnt_reg <= rty_cnt_reg + 1'b1;
			end
		end
	end

	// Open-drain fault pin: drive low only while fault held
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_out_low_o <= 1'b0;
			fault_out_low_oe <= 1'b0;
		end else begin
			fault_out_low_o <= 1'b0;
			fault_out_low_oe <= fault_reg;
		end
	end

	// Thermal flag follows the hysteresis comparator
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			thermal_reg <= 1'b0;
		end else begin
			thermal_reg <= thermal_hot;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_fwd_drive: assert property (@(posedge core_clk) disable iff (!arst_n)
		(fwd && !kill && chop_reg == DCBD_DRIVE) |=> (bridge_out_a == 2'b10))
		else $error("forward drive wrong");
	a_brake_low: assert property (@(posedge core_clk) disable iff (!arst_n)
		(cmd.input_a && cmd.input_b && !kill) |=> (bridge_out_a == 2'b01 && bridge_out_b == 2'b01))
		else $error("brake wrong");
	a_coast_off: assert property (@(posedge core_clk) disable iff (!arst_n)
		coast |=> (bridge_out_a == 2'b00 && bridge_out_b == 2'b00))
		else $error("coast not off");
	a_fwd_chop: assert property (@(posedge core_clk) disable iff (!arst_n)
		(fwd && !kill && chop_reg == DCBD_SLOW) |=> (bridge_out_a == 2'b01))
		else $error("forward chop wrong");
	a_rev_chop: assert property (@(posedge core_clk) disable iff (!arst_n)
		(rev && !kill && chop_reg == DCBD_FAST) |=> (bridge_out_b == 2'b01))
		else $error("reverse chop wrong");
	a_trip_fast: assert property (@(posedge core_clk) disable iff (!arst_n)
		((fwd || rev) && !kill && chop_reg == DCBD_DRIVE && trip_cmp) |=> chop_reg == DCBD_FAST)
		else $error("trip ignored");
	a_dead_off: assert property (@(posedge core_clk) disable iff (!arst_n)
		(chop_reg == DCBD_DEAD) |=> (bridge_out_a.hi == 1'b0 && bridge_out_b.hi == 1'b0))
		else $error("dead time drives");
	a_kill_off: assert property (@(posedge core_clk) disable iff (!arst_n)
		(supply_lockout || thermal_reg) |=> (bridge_out_a == 2'b00 && bridge_out_b == 2'b00))
		else $error("lockout drives");
	a_fault_pin: assert property (@(posedge core_clk) disable iff (!arst_n)
		$rose(fault_reg) |=> fault_out_low_oe)
		else $error("fault pin idle");
	a_fault_rel: assert property (@(posedge core_clk) disable iff (!arst_n)
		$fell(fault_reg) |=> !fault_out_low_oe)
		else $error("fault pin stuck");
	a_oc_qual: assert property (@(posedge core_clk) disable iff (!arst_n)
		(!fault_reg && $rose(overcurrent_guard)) |=> !fault_reg)
		else $error("unqualified fault");
	a_latch_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
		(fault_reg && latch_mode && !standby) |=> fault_reg)
		else $error("latched fault lost");
	c_chop: cover property (@(posedge core_clk) disable iff (!arst_n) chop_reg == DCBD_SLOW);
	c_fault: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(fault_reg));
	c_retry: cover property (@(posedge core_clk) disable iff (!arst_n)
		$fell(fault_reg) && !standby);
	c_sby: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(standby));

endmodule

// ==== tb/dcbd_host.sv ====
// Host controller model that drives the two direction inputs
`timescale 1ns/1ps
module dcbd_host
	import dcbd_pkg::*;
#(
	parameter int SETTLE = 30  // Wake settle in cycles, shortened
) (
	// Clock
	input  wire logic          core_clk,
	// Device status
	input  wire logic          standby,
	// Direction inputs
	output dcbd_pkg::dcbd_cmd_t cmd
);
	// ------------------------------------------------------------
	// Command driver
	// ------------------------------------------------------------
	// Coast from time zero, so the device may fall asleep
	initial cmd = '0;

	// Change the inputs just after a falling edge
	task automatic go(input logic [1:0] c);
		logic woke;
		@(negedge core_clk);
		woke = standby && (c != 2'h0);
		cmd = dcbd_cmd_t'(c);
		// Charge pump is still rising, so hold off the next command
		if (woke) begin
			repeat (SETTLE) @(negedge core_clk);
		end
	endtask
endmodule

// ==== tb/dcbd_top_tb.sv ====
// Self-checking testbench for the DC bridge drive control block
`timescale 1ns/1ps
module dcbd_top_tb;
	import dcbd_pkg::*;
	// ------------------------------------------------------------
	// Signals and counts
	// ------------------------------------------------------------
	localparam int OFF_P = 40;        // Short off-time
	localparam int STB_P = 50;        // Short standby delay
	localparam int RTY_P = 60;        // Short retry delay
	logic      core_clk;              // Core clock
	logic      arst_n;                // Reset, active low
	dcbd_cmd_t cmd;                   // From host model
	logic      retry_select;          // Retry mode
	logic      trip_cmp;              // Current trip
	logic      overcurrent_guard;     // Raw short detect
	logic      thermal_hot;           // Thermal comparator
	logic      supply_lockout;        // Undervoltage comparator
	dcbd_leg_t bridge_out_a;
	dcbd_leg_t bridge_out_b;
	logic      standby;
	logic      fault_out_low_o;
	logic      fault_out_low_oe;
	int        errors = 0;
	int        n_tests = 0;

	// 4 ns clock
	always #2 core_clk = ~core_clk;

	dcbd_host #(.SETTLE(20)) u_dcbd_host (.core_clk(core_clk), .standby(standby), .cmd(cmd));
	dcbd_top #(.OFF_CYC(OFF_P), .STANDBY_P(STB_P), .RETRY_P(RTY_P), .HAS_RETRY(1'b1)) u_dcbd_top (
		.core_clk(core_clk), .arst_n(arst_n), .cmd(cmd), .retry_select(retry_select),
		.trip_cmp(trip_cmp), .overcurrent_guard(overcurrent_guard),
		.thermal_hot(thermal_hot), .supply_lockout(supply_lockout),
		.bridge_out_a(bridge_out_a), .bridge_out_b(bridge_out_b), .standby(standby),
		.fault_out_low_o(fault_out_low_o), .fault_out_low_oe(fault_out_low_oe));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// Gates as {a.hi, a.lo, b.hi, b.lo}
	function automatic logic gates(input logic [3:0] v);
		return {bridge_out_a, bridge_out_b} === v;
	endfunction

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Forward, reverse, brake, coast
	task automatic t_modes();
		logic [1:0] c [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
		logic [3:0] e [4] = '{4'h9, 4'h6, 4'h5, 4'h0};
		for (int i = 0; i < 4; i++) begin
			u_dcbd_host.go(c[i]);
			cyc(3);
			chk(gates(e[i]), "mode gates");
		end
	endtask

	// One trip: fast, dead, slow, then the pair again
	task automatic t_chop(input logic [1:0] c, input logic [3:0] drv, input logic [3:0] fast);
		int n_dead = 0;
		int w_dead = 0;
		int n = 3;
		logic slow = 1'b0;
		u_dcbd_host.go(c);
		cyc(3);
		chk(gates(drv), "drive pair");
		trip_cmp = 1'b1;
		cyc(1);
		trip_cmp = 1'b0;
		cyc(2);
		chk(gates(fast), "fast decay");
		while (!gates(drv) && n < 100) begin
			if (gates(4'h0)) begin
				w_dead++;
				n_dead = (n_dead == 0) ? n : n_dead;
			end
			slow |= gates(4'h5);
			cyc(1);
			n++;
		end
		chk(n >= OFF_P - 3 && n <= OFF_P + 3, "off-time");
		chk(n_dead >= OFF_P / 2 && n_dead <= OFF_P / 2 + 3, "fast half");
		chk(w_dead == DEAD_TIME_CYC && slow, "dead then slow");
	endtask

	// Thermal and supply lockouts
	task automatic t_guard();
		u_dcbd_host.go(2'h2);
		for (int i = 0; i < 2; i++) begin
			{thermal_hot, supply_lockout} = i ? 2'h1 : 2'h2;
			cyc(3);
			chk(gates(4'h0), "lockout gates");
			{thermal_hot, supply_lockout} = 2'h0;
			cyc(3);
			chk(gates(4'h9), "lockout release");
		end
	endtask

	// Short glitch ignored, real short faults, then retry or latch
	task automatic t_fault(input logic keep);
		retry_select = keep;
		u_dcbd_host.go(2'h2);
		overcurrent_guard = 1'b1;
		cyc(100);
		overcurrent_guard = 1'b0;
		cyc(5);
		chk(fault_out_low_oe === 1'b0, "glitch faulted");
		overcurrent_guard = 1'b1;
		cyc(260);
		chk(fault_out_low_oe === 1'b1 && fault_out_low_o === 1'b0, "fault pin");
		chk(gates(4'h0), "fault gates");
		overcurrent_guard = 1'b0;
		cyc(RTY_P - 20);
		chk(fault_out_low_oe === 1'b1, "early clear");
		cyc(40);
		if (!keep) begin
			chk(fault_out_low_oe === 1'b0 && gates(4'h9), "retry");
		end else begin
			chk(fault_out_low_oe === 1'b1 && gates(4'h0), "latch");
			u_dcbd_host.go(2'h0);
			cyc(STB_P + 10);
			chk(standby === 1'b1 && fault_out_low_oe === 1'b0, "latch clear");
			u_dcbd_host.go(2'h2);
			cyc(3);
			chk(gates(4'h9), "drive after clear");
		end
	endtask

	// Coast long enough to sleep
	task automatic t_standby();
		u_dcbd_host.go(2'h0);
		cyc(STB_P - 5);
		chk(standby === 1'b0, "early standby");
		cyc(10);
		chk(standby === 1'b1 && gates(4'h0), "standby");
	endtask

	// ------------------------------------------------------------
	// End of run
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Whole run is some 1200 cycles; 20000 cycles is a hang
	initial begin
		#80000;
		errors++;
		complete_run();
	end

	// Main sequence
	initial begin
		// Every input but cmd is driven from here, cmd comes from the host model
		core_clk = 1'b0;
		arst_n = 1'b0;
		retry_select = 1'b0;
		trip_cmp = 1'b0;
		overcurrent_guard = 1'b0;
		thermal_hot = 1'b0;
		supply_lockout = 1'b0;
		cyc(3);
		chk(standby === 1'b1 && gates(4'h0) && fault_out_low_oe === 1'b0, "reset");
		arst_n = 1'b1;
		t_modes();
		t_chop(2'h2, 4'h9, 4'h6);
		t_chop(2'h1, 4'h6, 4'h9);
		t_guard();
		t_fault(1'b0);
		t_fault(1'b1);
		t_standby();
		complete_run();
	end
endmodule
